// ===== pkg/dual_uart_params.svh
// Purpose: offsets, field positions and reset values
// Assumes: byte addresses on a 32-bit bus
// Notes: region is haddr[6:5], register is haddr[4:0]
`ifndef DUAL_UART_PARAMS_SVH
`define DUAL_UART_PARAMS_SVH
// ----------------------------------------
// regions
// ----------------------------------------
`define RGN_SER_ONE 2'h0
`define RGN_SER_TWO 2'h1
`define RGN_PRINTER 2'h2
`define RGN_IRQ 2'h3
// ----------------------------------------
// register offsets within a region
// ----------------------------------------
`define REG_MODEM_STATUS 5'h00
`define REG_MODEM_CONTROL 5'h04
`define REG_IER 5'h08
`define REG_PSTAT 5'h00
`define REG_PCTL 5'h04
`define REG_ISTAT 5'h00
`define REG_ICLR 5'h04
`define REG_IEN 5'h08
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTS_CHANGE_FLAG 0
`define DSR_CHANGE_FLAG 1
`define CARRIER_CHANGE_FLAG 3
`define CTS_STATE_BIT 4
`define DSR_STATE_BIT 5
`define CARRIER_STATE_BIT 7
`define DTR_CONTROL_BIT 0
`define CTL_IRQ_OE 3
`define IER_RX_AVAIL 0
`define IER_THRE 1
`define IER_RX_ERR 2
`define IER_MODEM 3
`define PST_PRINT_N 2
`define PST_ERR_N 3
`define PST_INIT_IN 4
`define PCTL_INIT 0
`define IRQ_CH1 0
`define IRQ_CH2 1
`define IRQ_ACK 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define IER_RST 4'h0
`define IEN_RST 3'h0
`define IST_RST 3'h0
`endif

// ===== pkg/dual_uart_pkg.sv
// Purpose: types shared by the block and its bench
// Assumes: two serial channels
// Notes: all state of the top is one state_s
package dual_uart_pkg;
	typedef enum logic [1:0] {ph_idle, ph_write, ph_rwait} phase_e;
	// modem pins, active low
	typedef struct packed {
		logic dcd_n;
		logic dsr_n;
		logic cts_n;
	} modem_in_s;
	// level sources from the channel core
	typedef struct packed {
		logic rx_err;
		logic rx_avail;
		logic thr_empty;
	} ser_src_s;
	typedef struct packed {
		logic dtr_n;
		logic irq_oe_n;
		logic [3:0] ier;
		logic [2:0] lvl;
		logic [2:0] chg;
		logic irq;
	} chan_s;
	typedef struct packed {
		phase_e phase;
		logic [6:0] addr;
		chan_s [1:0] ch;
		logic ack_prev;
		logic latch;
		logic prn_irq;
		logic init_oe_n;
		logic [2:0] ist;
		logic [2:0] ien;
		logic irq;
		logic [7:0] hrdata;
		logic hready;
	} state_s;
endpackage : dual_uart_pkg

// ===== core/dual_uart_pins_irq.sv
// Purpose: modem status, modem control and interrupt pins of a dual serial port
// Assumes: single AHB-Lite master, word accesses only
// Notes: reads take one wait state, writes none
//   byte map, region in haddr[6:5], register in haddr[4:0]
//   0x00 modem status of channel one, read only, read clears change flags
//   0x04 modem control of channel one, bit 0 terminal ready, bit 3 irq drive
//   0x08 interrupt enable of channel one, bits 0 to 3
//   0x20 to 0x28 the same three registers for channel two
//   0x40 printer status, read only, read clears latch in latched mode
//   0x44 printer control, bit 0 pulls initialize low
//   0x60 block interrupt status, sticky, read only
//   0x64 block interrupt clear, write one to clear, set wins
//   0x68 block interrupt enable
//   unmapped offsets read zero and ignore writes
//   modem pins are active low, status bits show the asserted level
//   a change flag set and cleared in one cycle stays set
//   printer interrupt is registered, one edge behind acknowledge
//   channel interrupt value keeps following its enabled sources while its pin floats
//   all inputs are taken as synchronous to hclk
//
// What this block does
// R1 - host accesses reach channel one, channel two or printer port by their select
// R2 - clear-to-send logical state reads in modem status bit 4
// R3 - modem status bit 0 sets when clear-to-send changed since last read
// R4 - read data lines are quiet except while a read returns data
// R5 - bus bit zero is the least significant bit of every byte
// R6 - carrier state in status bit 7, its change flag in bit 3
// R7 - carrier detect is status only, never touching the receiver
// R8 - data-set-ready state in status bit 5, its change flag in bit 1
// R9 - terminal ready pin low while control bit 0 set, high after reset
// R10 - mode select low: printer interrupt follows acknowledge directly
// R11 - mode select high: acknowledge rising edge latches printer interrupt high
// R12 - latched mode: printer status read clears the latch and interrupt
// R13 - channel interrupt pin driven only while control bit 3 set
// R14 - channel interrupt high when any enabled source is active
// R15 - channel interrupt drops once the serviced source clears
// R16 - channel interrupt pins float from reset
// R17 - printer holds error input low for as long as error lasts
// R18 - open-drain active-low printer initialize output
// R19 - reading modem status clears its change flags
`timescale 1ns/10ps
`default_nettype none
`include "dual_uart_params.svh"

module dual_uart_pins_irq #(
	parameter int ADDR_W = 7
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire dual_uart_pkg::modem_in_s [1:0] modem_pins,
	input wire dual_uart_pkg::ser_src_s [1:0] ser_src,
	output logic [1:0] dtr_n,
	output logic serial_irq_one,
	output logic serial_irq_one_oe_n,
	output logic serial_irq_two,
	output logic serial_irq_two_oe_n,
	input wire logic ack_n,
	input wire logic printer_irq_mode_select,
	input wire logic err_n,
	output logic printer_irq_out,
	input wire logic init_in,
	output logic init_out,
	output logic init_oe_n,
	output logic irq
);

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	// one-hot select per region
	function automatic logic [3:0] sel_of(input logic [6:0] a);
		logic [3:0] s;
		s = 4'h0;
		s[a[6:5]] = 1'b1;
		return s;
	endfunction : sel_of

	// modem status byte of one channel
	function automatic logic [7:0] stat_byte(input dual_uart_pkg::chan_s c);
		logic [7:0] b;
		b = 8'h00;
		// R2 clear-to-send state
		b[`CTS_STATE_BIT] = c.lvl[0];
		// R8 data-set-ready
		b[`DSR_STATE_BIT] = c.lvl[1];
		// R6 carrier state
		b[`CARRIER_STATE_BIT] = c.lvl[2];
		// R3 change flags
		b[`CTS_CHANGE_FLAG] = c.chg[0];
		b[`DSR_CHANGE_FLAG] = c.chg[1];
		b[`CARRIER_CHANGE_FLAG] = c.chg[2];
		return b;
	endfunction : stat_byte

	// modem control byte of one channel
	function automatic logic [7:0] ctl_byte(input dual_uart_pkg::chan_s c);
		logic [7:0] b;
		b = 8'h00;
		b[`DTR_CONTROL_BIT] = ~c.dtr_n;
		b[`CTL_IRQ_OE] = ~c.irq_oe_n;
		return b;
	endfunction : ctl_byte

	// printer status byte
	function automatic logic [7:0] prn_byte(input logic lt, input logic er, input logic iv);
		logic [7:0] b;
		b = 8'h00;
		b[`PST_PRINT_N] = ~lt;
		// R17 error level
		b[`PST_ERR_N] = er;
		b[`PST_INIT_IN] = iv;
		return b;
	endfunction : prn_byte

	// enabled sources of one channel
	function automatic logic irq_of(input logic [3:0] ier, input logic [3:0] src);
		logic [3:0] m;
		m = {ier[`IER_MODEM], ier[`IER_RX_ERR], ier[`IER_THRE], ier[`IER_RX_AVAIL]};
		return |(src & m);
	endfunction : irq_of

	// per-pin change between two samples
	function automatic logic [2:0] diff_of(input logic [2:0] now, input logic [2:0] was);
		return now ^ was;
	endfunction : diff_of

	// rising edge of a level
	function automatic logic rise_of(input logic now, input logic was);
		return now & ~was;
	endfunction : rise_of

	// ----------------------------------------
	// state
	// ----------------------------------------
	dual_uart_pkg::state_s r;
	dual_uart_pkg::state_s n;

	always_comb begin
		logic [3:0] sel;
		logic [4:0] ofs;
		logic [7:0] wd;
		logic [7:0] rv;
		logic [1:0] stat_rd;
		logic prn_rd;
		logic [2:0] lvl;
		logic [2:0] ev;
		logic [2:0] icl;
		logic [3:0] src;
		n = r;
		sel = sel_of(r.addr);
		ofs = r.addr[4:0];
		// R5 bit zero order
		wd = hwdata[7:0];
		rv = 8'h00;
		stat_rd = 2'b00;
		prn_rd = 1'b0;
		ev = 3'h0;
		icl = 3'h0;
		lvl = 3'h0;
		src = 4'h0;
		n.ack_prev = ack_n;
		n.hready = 1'b1;
		// R4 quiet data lines
		n.hrdata = 8'h00;

		// ----------------------------------------
		// write data phase
		// ----------------------------------------
		if (r.phase == dual_uart_pkg::ph_write) begin
			for (int i = 0; i < 2; i++) begin
				// R1 channel select
				if (sel[i]) begin
					if (ofs == `REG_MODEM_CONTROL) begin
						// R9 terminal ready
						n.ch[i].dtr_n = ~wd[`DTR_CONTROL_BIT];
						n.ch[i].irq_oe_n = ~wd[`CTL_IRQ_OE];
					end
					if (ofs == `REG_IER) begin
						n.ch[i].ier = wd[3:0];
					end
				end
			end
			// R1 printer select
			if (sel[`RGN_PRINTER] && ofs == `REG_PCTL) begin
				// R18 initialize drive
				n.init_oe_n = ~wd[`PCTL_INIT];
			end
			if (sel[`RGN_IRQ]) begin
				if (ofs == `REG_ICLR) begin
					icl = wd[2:0];
				end
				if (ofs == `REG_IEN) begin
					n.ien = wd[2:0];
				end
			end
		end

		// ----------------------------------------
		// read completion
		// ----------------------------------------
		if (r.phase == dual_uart_pkg::ph_rwait) begin
			for (int i = 0; i < 2; i++) begin
				if (sel[i]) begin
					case (ofs)
						`REG_MODEM_STATUS: begin
							rv = stat_byte(r.ch[i]);
							stat_rd[i] = 1'b1;
						end
						`REG_MODEM_CONTROL: begin
							rv = ctl_byte(r.ch[i]);
						end
						`REG_IER: begin
							rv[3:0] = r.ch[i].ier;
						end
						default: begin
							rv = 8'h00;
						end
					endcase
				end
			end
			if (sel[`RGN_PRINTER]) begin
				case (ofs)
					`REG_PSTAT: begin
						rv = prn_byte(r.latch, err_n, init_in);
						prn_rd = 1'b1;
					end
					`REG_PCTL: begin
						rv[`PCTL_INIT] = ~r.init_oe_n;
					end
					default: begin
						rv = 8'h00;
					end
				endcase
			end
			if (sel[`RGN_IRQ]) begin
				case (ofs)
					`REG_ISTAT: begin
						rv[2:0] = r.ist;
					end
					`REG_IEN: begin
						rv[2:0] = r.ien;
					end
					default: begin
						rv = 8'h00;
					end
				endcase
			end
			n.hrdata = rv;
		end

		// ----------------------------------------
		// address phase
		// ----------------------------------------
		n.phase = dual_uart_pkg::ph_idle;
		if (hsel && htrans[1] && hready) begin
			n.addr = haddr[6:0];
			if (hwrite) begin
				n.phase = dual_uart_pkg::ph_write;
			end else begin
				n.phase = dual_uart_pkg::ph_rwait;
				n.hready = 1'b0;
			end
		end

		// ----------------------------------------
		// modem status per channel
		// ----------------------------------------
		for (int i = 0; i < 2; i++) begin
			// R7 carrier only feeds status
			lvl = {~modem_pins[i].dcd_n, ~modem_pins[i].dsr_n,
				~modem_pins[i].cts_n};
			n.ch[i].lvl = lvl;
			// R19 clear on status read
			if (stat_rd[i]) begin
				n.ch[i].chg = 3'h0;
			end
			// R3 change flags, set wins
			n.ch[i].chg = n.ch[i].chg | diff_of(lvl, r.ch[i].lvl);
			ev[i] = |diff_of(lvl, r.ch[i].lvl);
			src = {|n.ch[i].chg, ser_src[i].rx_err,
				ser_src[i].thr_empty, ser_src[i].rx_avail};
			// R14 enabled sources
			// R15 level follows source
			n.ch[i].irq = irq_of(n.ch[i].ier, src);
		end

		// ----------------------------------------
		// printer interrupt
		// ----------------------------------------
		ev[`IRQ_ACK] = rise_of(ack_n, r.ack_prev);
		// R12 status read clears
		if (prn_rd && printer_irq_mode_select) begin
			n.latch = 1'b0;
		end
		// R11 latch on rising edge
		if (printer_irq_mode_select && ev[`IRQ_ACK]) begin
			n.latch = 1'b1;
		end
		if (!printer_irq_mode_select) begin
			n.latch = 1'b0;
		end
		if (printer_irq_mode_select) begin
			n.prn_irq = n.latch;
		end else begin
			// R10 direct follow
			n.prn_irq = ack_n;
		end

		// ----------------------------------------
		// block interrupt
		// ----------------------------------------
		n.ist = (r.ist & ~icl) | ev;
		n.irq = |(n.ist & n.ien);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r.phase <= dual_uart_pkg::ph_idle;
			r.addr <= 7'h00;
			for (int i = 0; i < 2; i++) begin
				// R9 high on reset
				r.ch[i].dtr_n <= 1'b1;
				// R16 float on reset
				r.ch[i].irq_oe_n <= 1'b1;
				r.ch[i].ier <= `IER_RST;
				r.ch[i].lvl <= 3'h0;
				r.ch[i].chg <= 3'h0;
				r.ch[i].irq <= 1'b0;
			end
			r.ack_prev <= 1'b1;
			r.latch <= 1'b0;
			r.prn_irq <= 1'b0;
			r.init_oe_n <= 1'b1;
			r.ist <= `IST_RST;
			r.ien <= `IEN_RST;
			r.irq <= 1'b0;
			r.hrdata <= 8'h00;
			r.hready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hreadyout = r.hready;
	assign hrdata = {24'h000000, r.hrdata};
	assign hresp = 1'b0;
	assign dtr_n = {r.ch[1].dtr_n, r.ch[0].dtr_n};
	// R13 drive only when enabled
	assign serial_irq_one = r.ch[0].irq;
	assign serial_irq_one_oe_n = r.ch[0].irq_oe_n;
	assign serial_irq_two = r.ch[1].irq;
	assign serial_irq_two_oe_n = r.ch[1].irq_oe_n;
	assign printer_irq_out = r.prn_irq;
	// R18 open drain pulls low
	assign init_out = 1'b0;
	assign init_oe_n = r.init_oe_n;
	assign irq = r.irq;

endmodule : dual_uart_pins_irq
`default_nettype wire

// ===== test/dual_uart_far_end.sv
// Purpose: modem, channel source and printer lines facing the block
// Assumes: bench sets requests just after a clock edge
// Notes: requests are active high, pins active low
`timescale 1ns/10ps
`default_nettype none
module dual_uart_far_end (
	input wire logic [5:0] m_req,
	input wire logic [5:0] s_req,
	input wire logic ack_req,
	input wire logic err_req,
	input wire logic init_out,
	input wire logic init_oe_n,
	output var dual_uart_pkg::modem_in_s [1:0] modem_pins,
	output var dual_uart_pkg::ser_src_s [1:0] ser_src,
	output logic ack_n,
	output logic err_n,
	output logic init_in
);
	assign modem_pins = ~m_req;
	assign ser_src = s_req;
	assign ack_n = ~ack_req;
	// error held low while it lasts
	assign err_n = ~err_req;
	assign init_in = init_oe_n ? 1'b1 : init_out;
endmodule : dual_uart_far_end
`default_nettype wire

// ===== test/dual_uart_pins_irq_asserts.sv
// Purpose: port checks of the modem and interrupt pins block
// Assumes: hready tied to hreadyout
// Notes: one clock domain
`timescale 1ns/10ps
`default_nettype none
module dual_uart_pins_irq_asserts #(
	parameter int ADDR_W = 7
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [1:0] dtr_n,
	input wire logic serial_irq_one_oe_n,
	input wire logic serial_irq_two_oe_n,
	input wire logic ack_n,
	input wire logic printer_irq_mode_select,
	input wire logic printer_irq_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_s;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence wr_s(a);
		hsel && htrans[1] && hready && hwrite && haddr == a ##1 1'b1;
	endsequence
	reset_float_a: assert property ($rose(hresetn) |->
		dtr_n == 2'h3 && serial_irq_one_oe_n && serial_irq_two_oe_n) else $error("reset pins");
	read_wait_a: assert property (rd_s |=> wait_s) else $error("read wait");
	hrdata_quiet_a: assert property (hrdata != 32'h0 |-> !$past(hreadyout))
		else $error("hrdata busy");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
	mcr_one_a: assert property (wr_s(7'h04) |=> dtr_n[0] == !$past(hwdata[0]) &&
		serial_irq_one_oe_n == !$past(hwdata[3])) else $error("ch1 control");
	mcr_two_a: assert property (wr_s(7'h24) |=> dtr_n[1] == !$past(hwdata[0]) &&
		serial_irq_two_oe_n == !$past(hwdata[3])) else $error("ch2 control");
	direct_follow_a: assert property ($past(hresetn) && !$past(printer_irq_mode_select)
		|-> printer_irq_out == $past(ack_n)) else $error("direct mode");
	latch_rise_a: assert property (printer_irq_mode_select && $rose(ack_n)
		|-> ##[1:2] printer_irq_out) else $error("latch set");
endmodule : dual_uart_pins_irq_asserts
`default_nettype wire

// ===== test/dual_uart_pins_irq_tb.sv
// Purpose: bench of the modem and interrupt pins block
// Assumes: one bus master, hsel tied high
// Notes: expected values from the register map
`timescale 1ns/10ps
`default_nettype none
module dual_uart_pins_irq_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [6:0] haddr = 7'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [5:0] m_req = 6'h0;
	logic [5:0] s_req = 6'h0;
	logic ack_req = 1'b0;
	logic printer_irq_mode_select = 1'b0;
	logic err_req = 1'b0;
	logic hresp;
	logic [5:0] sb;
	logic [31:0] hrdata;
	logic [1:0] dtr_n;
	logic hreadyout, serial_irq_one, serial_irq_one_oe_n, serial_irq_two, serial_irq_two_oe_n;
	logic ack_n, err_n, printer_irq_out, init_in, init_out, init_oe_n, irq;
	dual_uart_pkg::modem_in_s [1:0] modem_pins;
	dual_uart_pkg::ser_src_s [1:0] ser_src;
	int err_count = 0;
	int total_checks = 0;
	always #20 hclk = ~hclk;
	dual_uart_far_end far (.m_req, .s_req, .ack_req, .err_req, .init_out, .init_oe_n,
		.modem_pins, .ser_src, .ack_n, .err_n, .init_in);
	dual_uart_pins_irq uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .modem_pins,
		.ser_src, .dtr_n, .serial_irq_one, .serial_irq_one_oe_n, .serial_irq_two,
		.serial_irq_two_oe_n, .ack_n, .printer_irq_mode_select, .err_n, .printer_irq_out,
		.init_in, .init_out, .init_oe_n, .irq);
	task automatic end_of_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic bus(logic w, logic [6:0] a, logic [31:0] d, output logic [31:0] q);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : bus
	task automatic drive(logic [5:0] m, logic [5:0] s, logic a);
		m_req <= m;
		s_req <= s;
		ack_req <= a;
		repeat (3) @(posedge hclk);
	endtask : drive
	task automatic wr(logic [6:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		drive(m_req, s_req, ack_req);
	endtask : wr
	task automatic rc(string n, logic [6:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask : rc
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("rst", 32'hf, {dtr_n, serial_irq_one_oe_n, serial_irq_two_oe_n});
		chk("hresp", 32'h0, hresp);
		chk("init_out", 32'h0, init_out);
		rc("stat1", 7'h00, 32'h0);
		rc("hole", 7'h0c, 32'h0);
		drive(6'h01, 6'h0, 1'b0);
		rc("stat1", 7'h00, 32'h11);
		rc("stat1", 7'h00, 32'h10);
		drive(6'h31, 6'h0, 1'b0);
		rc("stat2", 7'h20, 32'haa);
		rc("stat1", 7'h00, 32'h10);
		rc("ist", 7'h60, 32'h3);
		wr(7'h68, 32'h1);
		chk("irq", 32'h1, irq);
		rc("ien", 7'h68, 32'h1);
		wr(7'h64, 32'h3);
		rc("ist", 7'h60, 32'h0);
		chk("irq", 32'h0, irq);
		drive(6'h01, 6'h0, 1'b0);
		rc("ist", 7'h60, 32'h2);
		chk("irq", 32'h0, irq);
		wr(7'h04, 32'h09);
		chk("ch1 pins", 32'h4, {dtr_n, serial_irq_one_oe_n});
		rc("ctl1", 7'h04, 32'h9);
		for (int i = 0; i < 3; i++) begin
			sb = (i == 0) ? 6'h2 : (i == 1) ? 6'h1 : 6'h4;
			wr(7'h08, 32'h1 << i);
			drive(6'h01, ~sb & 6'h7, 1'b0);
			chk("irq1 masked", 32'h0, serial_irq_one);
			drive(6'h01, sb, 1'b0);
			chk("irq1", 32'h1, serial_irq_one);
			drive(6'h01, 6'h0, 1'b0);
			chk("irq1 off", 32'h0, serial_irq_one);
		end
		wr(7'h08, 32'h8);
		drive(6'h00, 6'h0, 1'b0);
		chk("irq1 modem", 32'h1, serial_irq_one);
		rc("ier1", 7'h08, 32'h8);
		rc("stat1", 7'h00, 32'h01);
		drive(6'h00, 6'h0, 1'b0);
		chk("irq1 served", 32'h0, serial_irq_one);
		wr(7'h04, 32'h0);
		wr(7'h24, 32'h09);
		chk("pins", 32'h6, {dtr_n, serial_irq_one_oe_n, serial_irq_two_oe_n});
		wr(7'h28, 32'h1);
		drive(6'h0, 6'h10, 1'b0);
		chk("irq2", 32'h1, serial_irq_two);
		drive(6'h0, 6'h0, 1'b1);
		chk("direct low", 32'h0, printer_irq_out);
		drive(6'h0, 6'h0, 1'b0);
		chk("direct high", 32'h1, printer_irq_out);
		printer_irq_mode_select <= 1'b1;
		drive(6'h0, 6'h0, 1'b1);
		chk("latch idle", 32'h0, printer_irq_out);
		drive(6'h0, 6'h0, 1'b0);
		chk("latch set", 32'h1, printer_irq_out);
		rc("pstat", 7'h40, 32'h18);
		drive(6'h0, 6'h0, 1'b0);
		chk("latch clr", 32'h0, printer_irq_out);
		rc("pstat", 7'h40, 32'h1c);
		wr(7'h44, 32'h1);
		chk("init", 32'h0, init_oe_n);
		rc("pstat", 7'h40, 32'h0c);
		rc("pctl", 7'h44, 32'h1);
		err_req <= 1'b1;
		drive(6'h0, 6'h0, 1'b0);
		rc("pstat", 7'h40, 32'h04);
		rc("ist", 7'h60, 32'h7);
		chk("irq", 32'h1, irq);
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge hclk);
		err_count++;
		end_of_test();
	end
endmodule : dual_uart_pins_irq_tb
bind dual_uart_pins_irq dual_uart_pins_irq_asserts #(.ADDR_W(ADDR_W)) chk_i (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .dtr_n,
	.serial_irq_one_oe_n, .serial_irq_two_oe_n, .ack_n, .printer_irq_mode_select,
	.printer_irq_out);
`default_nettype wire
